// ### verilog/thw_pkg.sv
package thw_pkg;
   // wetting current codes as programmed per channel
   typedef enum logic [2:0] {
      THW_WC_0MA,
      THW_WC_1MA,
      THW_WC_2MA,
      THW_WC_5MA,
      THW_WC_10MA,
      THW_WC_15MA
   } thw_wc_e;

   typedef enum logic [1:0] {
      THW_ST_NORMAL,
      THW_ST_WARN,
      THW_ST_SHUT
   } thw_state_e;

   // synchronised comparator levels
   typedef struct packed {
      logic warn;
      logic shut;
   } thw_temp_s;

   // interrupt flag register bits
   typedef struct packed {
      logic warn;
      logic shut;
   } thw_flags_s;

   // temperatures in degrees Celsius, realised by the analog comparators
   localparam int THW_WARN_TRIP_C = 140;
   localparam int THW_SHUT_TRIP_C = 160;
   localparam int THW_HYST_C = 15;

   // serial frame: read/write bit then register address, msb first
   localparam logic [2:0] THW_CMD_LAST_BIT = 3'h6;
   localparam logic [5:0] THW_INT_FLAG_ADDR = 6'h01;
   localparam logic THW_CMD_READ = 1'h0;
   localparam int THW_NCH = 24;
   localparam int THW_GROUP_O_NCH = 10;
endpackage

// ### verilog/thw_thermal_ctrl.sv
// Overview of operation
// RL1: warning entry pulls interrupt, sets warning flag
// RL2: thermal flag reported while events flagged
// RL3: warning entry sets live warning bit
// RL4: warning derates 10/15 mA to 2 mA
// RL5: lower current settings stay unchanged in warning
// RL6: derating held until below warning hysteresis
// RL7: read flags then chip-select rise clears
// RL8: no repeat interrupts while still hot
// RL9: live warning bit follows warning condition
// RL10: derate-off bit keeps full current, still interrupts
// RL11: warning exit interrupts, clears live bit, restores
// RL12: shutdown opens every current switch
// RL13: shutdown entry interrupts, sets shutdown flag
// RL14: shutdown sets live shutdown, keeps warning bit
// RL15: spi and register contents held in shutdown
// RL16: currents off until below shutdown hysteresis
// RL17: shutdown exit interrupts, keeps warning derating
// RL18: shutdown exit restarts polling, new defaults
// RL19: comparator outputs pass two-stage synchroniser
// RL20: warning trip at 140 C precedes shutdown
`timescale 1ns/1ns
`default_nettype none
module thw_thermal_ctrl
   import thw_pkg::*;
#(
   parameter int NCH = THW_NCH,
   parameter int GROUP_O_NCH = THW_GROUP_O_NCH
) (
   // core clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // analog comparators, hysteresis built in
   input wire logic over_heat_warning,
   input wire logic thermal_shutdown,
   // serial link
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_sdi,
   // configuration
   input wire logic warn_derate_off_group_o,
   input wire logic warn_derate_off_group_i,
   input wire logic [3*NCH-1:0] wc_setting,
   // interrupt and status
   output logic int_n,
   output thw_pkg::thw_flags_s int_flags,
   output logic spi_temp_flag,
   output logic warn_live_state,
   output logic shutdown_live_state,
   // current drive and polling control
   output logic [3*NCH-1:0] wc_applied,
   output logic switches_open,
   output logic hold_switch_status,
   output logic poll_restart
);
   import thw_pkg::*;

   function automatic logic [2:0] derate(input logic [2:0] code, input logic cut);
      if (cut && (code == THW_WC_10MA || code == THW_WC_15MA)) begin
         derate = THW_WC_2MA; // RL4 RL5
      end else begin
         derate = code;
      end
   endfunction

   logic [1:0] rst_sync;
   logic rst_n;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'h1};
      end
   end
   assign rst_n = rst_sync[1];

   // link domain: spot a read of the flag register; idle sck never advances it
   logic [2:0] bit_cnt;
   logic [5:0] cmd_sh;
   logic read_tgl;
   wire logic [6:0] cmd_word = {cmd_sh, spi_sdi};
   wire logic read_hit = (bit_cnt == THW_CMD_LAST_BIT) && (cmd_word[6] == THW_CMD_READ)
                         && (cmd_word[5:0] == THW_INT_FLAG_ADDR);
   always_ff @(posedge spi_sck or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         bit_cnt <= 3'h0;
         cmd_sh <= 6'h00;
      end else begin
         if (bit_cnt != 3'h7) begin
            bit_cnt <= bit_cnt + 3'h1;
         end
         cmd_sh <= cmd_word[5:0];
      end
   end
   always_ff @(posedge spi_sck or negedge arst_n) begin
      if (!arst_n) begin
         read_tgl <= 1'h0;
      end else if (read_hit && !spi_cs_n) begin
         read_tgl <= ~read_tgl;
      end
   end

   // core domain synchronisers
   thw_temp_s temp_m, temp_s;
   logic [1:0] cs_sync;
   logic [1:0] tgl_sync;
   logic cs_prev, tgl_prev;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         temp_m <= '0;
         temp_s <= '0;
         cs_sync <= 2'h3;
         tgl_sync <= 2'h0;
         cs_prev <= 1'h1;
         tgl_prev <= 1'h0;
      end else begin
         temp_m <= '{warn: over_heat_warning, shut: thermal_shutdown}; // RL19
         temp_s <= temp_m; // RL19
         cs_sync <= {cs_sync[0], spi_cs_n};
         tgl_sync <= {tgl_sync[0], read_tgl};
         cs_prev <= cs_sync[1];
         tgl_prev <= tgl_sync[1];
      end
   end
   wire logic cs_rise = cs_sync[1] && !cs_prev;
   wire logic read_ev = tgl_sync[1] != tgl_prev;

   // read seen in this frame, consumed by the closing chip-select edge
   logic read_pend;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         read_pend <= 1'h0;
      end else if (read_ev) begin
         read_pend <= 1'h1;
      end else if (cs_rise) begin
         read_pend <= 1'h0;
      end
   end
   wire logic flag_clear = cs_rise && (read_pend || read_ev); // RL7

   // thermal state machine; entry and exit fire once each
   thw_state_e state, next_state;
   logic warn_ev, shut_ev, shut_exit;
   always_comb begin
      next_state = state;
      warn_ev = 1'h0;
      shut_ev = 1'h0;
      shut_exit = 1'h0;
      unique case (state)
         THW_ST_NORMAL: begin
            if (temp_s.warn) begin
               next_state = THW_ST_WARN; // RL1 RL20
               warn_ev = 1'h1;
            end
         end
         THW_ST_WARN: begin
            if (temp_s.shut) begin
               next_state = THW_ST_SHUT; // RL12 RL13
               shut_ev = 1'h1;
            end else if (!temp_s.warn) begin
               next_state = THW_ST_NORMAL; // RL6 RL11
               warn_ev = 1'h1;
            end
         end
         THW_ST_SHUT: begin
            if (!temp_s.shut) begin
               next_state = THW_ST_WARN; // RL16 RL17
               shut_ev = 1'h1;
               shut_exit = 1'h1;
            end
         end
      endcase
   end

   // set wins over clear; only state edges set, so no repeats while hot
   wire thw_flags_s next_flags = '{
      warn: warn_ev || (int_flags.warn && !flag_clear),
      shut: shut_ev || (int_flags.shut && !flag_clear)
   }; // RL8
   wire logic in_warn = (next_state != THW_ST_NORMAL);
   wire logic in_shut = (next_state == THW_ST_SHUT);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= THW_ST_NORMAL;
         int_flags <= '0;
         int_n <= 1'h1;
         spi_temp_flag <= 1'h0;
         warn_live_state <= 1'h0;
         shutdown_live_state <= 1'h0;
         switches_open <= 1'h0;
         hold_switch_status <= 1'h0;
         poll_restart <= 1'h0;
      end else begin
         state <= next_state;
         int_flags <= next_flags; // RL1 RL11 RL13 RL17
         int_n <= !(next_flags.warn || next_flags.shut); // RL1 RL7 RL13
         spi_temp_flag <= next_flags.warn || next_flags.shut; // RL2
         warn_live_state <= in_warn; // RL3 RL9 RL14 RL17
         shutdown_live_state <= in_shut; // RL14 RL17
         switches_open <= in_shut; // RL12 RL16
         hold_switch_status <= in_shut; // RL15
         poll_restart <= shut_exit; // RL18
      end
   end

   // per-channel applied current
   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch++) begin : g_ch
         wire logic keep_full = (ch < GROUP_O_NCH) ? warn_derate_off_group_o
                                                   : warn_derate_off_group_i;
         wire logic [2:0] cut_code = derate(wc_setting[3*ch +: 3], in_warn && !keep_full); // RL10
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               wc_applied[3*ch +: 3] <= THW_WC_0MA;
            end else begin
               wc_applied[3*ch +: 3] <= in_shut ? THW_WC_0MA : cut_code; // RL12 RL4
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ### tb/thw_checker.sv
`timescale 1ns/1ns
`default_nettype none
module thw_checker
   import thw_pkg::*;
#(
   parameter int NCH = THW_NCH
) (
   // core clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // watched ports
   input wire logic over_heat_warning,
   input wire logic spi_cs_n,
   input wire logic int_n,
   input wire thw_flags_s int_flags,
   input wire logic warn_live_state,
   input wire logic shutdown_live_state,
   input wire logic [3*NCH-1:0] wc_applied,
   input wire logic switches_open,
   input wire logic hold_switch_status,
   input wire logic poll_restart
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_exit; poll_restart ##1 !poll_restart; endsequence
   property p_wrise; $rose(warn_live_state) |-> !int_n && int_flags.warn; endproperty
   a_wrise: assert property (p_wrise) else $error("warn entry");
   property p_wsync;
      $rose(over_heat_warning) && !warn_live_state |-> ##[2:3] warn_live_state;
   endproperty
   a_wsync: assert property (p_wsync) else $error("warn latency");
   property p_wfall; $fell(warn_live_state) |-> !int_n && int_flags.warn; endproperty
   a_wfall: assert property (p_wfall) else $error("warn exit");
   property p_srise;
      $rose(shutdown_live_state) |-> switches_open && hold_switch_status && warn_live_state
         && int_flags.shut && !int_n;
   endproperty
   a_srise: assert property (p_srise) else $error("shut entry");
   property p_sfall;
      $fell(shutdown_live_state) |-> (int_flags.shut && warn_live_state) ##0 s_exit;
   endproperty
   a_sfall: assert property (p_sfall) else $error("shut exit");
   property p_shcur; shutdown_live_state |-> wc_applied == '0; endproperty
   a_shcur: assert property (p_shcur) else $error("current in shutdown");
   property p_clr; $rose(int_n) |-> spi_cs_n && $past(spi_cs_n); endproperty
   a_clr: assert property (p_clr) else $error("release without cs");
   property p_quiet; $fell(int_n) |-> $changed(warn_live_state) || $changed(shutdown_live_state); endproperty
   a_quiet: assert property (p_quiet) else $error("spurious interrupt");
endmodule
`default_nettype wire

// ### tb/thw_mcu_model.sv
`timescale 1ns/1ns
`default_nettype none
module thw_mcu_model (
   // serial link
   output logic spi_sck,
   output logic spi_cs_n,
   output logic spi_sdi
);
   initial begin
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      spi_sdi = 1'b1;
   end
   // sck stands still between frames; sdi has no pull, so flip it after use
   task automatic frame(input logic [6:0] cmd);
      spi_cs_n = 1'b0;
      for (int i = 6; i >= 0; i--) begin
         spi_sdi = cmd[i];
         #24 spi_sck = 1'b1;
         #24 spi_sck = 1'b0;
      end
      spi_sdi = ~spi_sdi;
      #200 spi_cs_n = 1'b1;
      #300;
   endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import thw_pkg::*;
   localparam int W = 3*THW_NCH;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic ow = 1'b0;
   logic ts = 1'b0;
   logic dfo = 1'b0;
   logic dfi = 1'b0;
   logic [W-1:0] wcs = '0;
   logic [1:0] ef = 2'h0;
   int st = 0;
   int n_mismatch = 0;
   int tests_run = 0;
   wire logic int_n, spi_temp_flag, warn_live_state, shutdown_live_state, spi_sck;
   wire logic switches_open, hold_switch_status, poll_restart, spi_cs_n, spi_sdi;
   wire thw_flags_s int_flags;
   wire logic [W-1:0] wc_applied;
   thw_thermal_ctrl i_thw_thermal_ctrl (.clk, .arst_n, .over_heat_warning(ow),
      .thermal_shutdown(ts), .spi_sck, .spi_cs_n, .spi_sdi, .warn_derate_off_group_o(dfo),
      .warn_derate_off_group_i(dfi), .wc_setting(wcs), .int_n, .int_flags, .spi_temp_flag,
      .warn_live_state, .shutdown_live_state, .wc_applied, .switches_open,
      .hold_switch_status, .poll_restart);
   thw_mcu_model i_mcu (.spi_sck, .spi_cs_n, .spi_sdi);
   always #25 clk = ~clk;
   function automatic logic [W-1:0] exp_wc();
      logic [W-1:0] v;
      int c;
      for (int n = 0; n < THW_NCH; n++) begin
         c = wcs[3*n +: 3];
         if (st == 2) c = 0;
         else if (st == 1 && c >= 4 && !(n < THW_GROUP_O_NCH ? dfo : dfi)) c = 2;
         v[3*n +: 3] = c[2:0];
      end
      return v;
   endfunction
   task automatic chk(input logic [W-1:0] seen, input logic [W-1:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cmp();
      #1;
      chk(W'({int_n, spi_temp_flag, int_flags, warn_live_state, shutdown_live_state,
         switches_open, hold_switch_status}), W'({ef == 2'h0, |ef, ef, st > 0, st == 2,
         st == 2, st == 2}));
      chk(wc_applied, exp_wc());
   endtask
   task automatic go(input logic w, input logic s, input int n, input logic [1:0] set);
      @(posedge clk);
      ow <= w;
      ts <= s;
      repeat (6) @(posedge clk);
      st = n;
      ef = ef | set;
      cmp();
   endtask
   // a write frame must leave the flags alone
   task automatic clr(input logic [6:0] c);
      i_mcu.frame(c);
      if (c == {THW_CMD_READ, THW_INT_FLAG_ADDR}) ef = 2'h0;
      cmp();
   endtask
   task automatic report_and_stop();
      $display("mismatches %0d checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      void'($urandom(32'hca3c));
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      cmp();
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         {dfo, dfi} <= 2'(k);
         for (int n = 0; n < THW_NCH; n++) wcs[3*n +: 3] <= 3'($urandom_range(5));
         go(1'b1, 1'b0, 1, 2'h2);
         clr(7'h41);
         clr({THW_CMD_READ, THW_INT_FLAG_ADDR});
         go(1'b1, 1'b0, 1, 2'h0);
         go(1'b1, 1'b1, 2, 2'h1);
         clr({THW_CMD_READ, THW_INT_FLAG_ADDR});
         go(1'b1, 1'b0, 1, 2'h1);
         go(1'b0, 1'b0, 0, 2'h2);
         clr({THW_CMD_READ, THW_INT_FLAG_ADDR});
      end
      report_and_stop();
   end
   initial begin
      #2000000;
      n_mismatch++;
      report_and_stop();
   end
endmodule
bind thw_thermal_ctrl thw_checker #(.NCH(NCH)) i_thw_checker (.clk, .arst_n, .over_heat_warning,
   .spi_cs_n, .int_n, .int_flags, .warn_live_state, .shutdown_live_state, .wc_applied,
   .switches_open, .hold_switch_status, .poll_restart);
`default_nettype wire
